// *** inc/serial_flash_defines.vh ***
`ifndef SERIAL_FLASH_DEFINES_VH
`define SERIAL_FLASH_DEFINES_VH
// register offsets
`define OFS_READ_SEL 8'hb7
`define OFS_DATA 8'hb8
`define OFS_CTRL 8'hb9
`define OFS_STATUS 8'hba
`define OFS_DIVISOR 8'hbb
// master control fields
`define CTRL_PHA 0
`define CTRL_POL 1
`define CTRL_EMT_EN 2
`define CTRL_OVF_EN 3
`define CTRL_ACTIVE 4
`define CTRL_CS_SEL 5
`define CTRL_MASK 6
// master status fields
`define ST_BUSY 0
`define ST_EMT 2
`define ST_OVF 3
`define ST_RX_FULL 4
`define ST_RX_EMPTY 5
`define ST_TX_FULL 6
`define ST_TX_EMPTY 7
// reset values
`define CTRL_RESET 8'h00
`define READ_SEL_RESET 8'h00
`define DIV_RESET 8'h1f
// read selector fields and codes
`define SEL_A32 5
`define RD_NORMAL 4'h0
`define RD_FAST 4'h4
`define RD_FASTEST 4'h8
`define RD_DUAL_OUT 4'h2
`define RD_DUAL_IO 4'h3
`define RD_QPI_FAST 4'h6
`define RD_QUAD_OUT 4'h7
// opcodes, 24-bit and 32-bit addressing
`define OP_NORMAL_24 8'h03
`define OP_NORMAL_32 8'h13
`define OP_FAST_24 8'h0b
`define OP_FAST_32 8'h0c
`define OP_FASTEST 8'h1b
`define OP_DUAL_OUT_24 8'h3b
`define OP_DUAL_OUT_32 8'h3c
`define OP_DUAL_IO_24 8'hbb
`define OP_DUAL_IO_32 8'hbc
`define OP_QUAD_OUT_24 8'h6b
`define OP_QUAD_OUT_32 8'h6c
// dummy clock counts
`define DUMMY_NONE 5'd0
`define DUMMY_2 5'd2
`define DUMMY_4 5'd4
`define DUMMY_8 5'd8
`define DUMMY_16 5'd16
// host port strap for 4-wire serial
`define STRAP_SERIAL4 3'b101
`endif

// *** src/serial_byte_fifo.v ***
`timescale 1ns/10ps
// ****************************************
// byte fifo, overwrite-oldest when full
// ****************************************
module serial_byte_fifo #(
  parameter WIDTH = 8,
  parameter ADDR_BITS = 4
) (
  input wire clk_in,
  input wire reset_in,
  input wire clear_in,
  input wire push_in,
  input wire [WIDTH-1:0] push_data_in,
  input wire pop_in,
  output reg [WIDTH-1:0] head_out,
  output wire empty_out,
  output wire full_out
);
  localparam [ADDR_BITS:0] DEPTH = {{ADDR_BITS{1'b0}}, 1'b1} << ADDR_BITS;
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
  reg [ADDR_BITS-1:0] wp; // write pointer
  reg [ADDR_BITS-1:0] rp; // read pointer
  reg [ADDR_BITS:0] count; // entries held
  wire do_pop = pop_in && (count != {(ADDR_BITS+1){1'b0}});
  wire [ADDR_BITS-1:0] rp_n = do_pop ? rp + 1'b1 : rp;
  assign empty_out = (count == {(ADDR_BITS+1){1'b0}});
  assign full_out = (count == DEPTH);
  // storage write; a push on full lands on the oldest slot
  always @(posedge clk_in) begin
    if (push_in && !clear_in) begin
      mem[wp] <= push_data_in;
    end
  end
  // head register follows the next read slot, bypassing a same-slot write
  always @(posedge clk_in) begin
    if (push_in && (wp == rp_n)) begin
      head_out <= push_data_in;
    end else begin
      head_out <= mem[rp_n];
    end
  end
  // pointers and fill level; read pointer never moves on overflow
  always @(posedge clk_in) begin
    if (reset_in || clear_in) begin
      wp <= {ADDR_BITS{1'b0}};
      rp <= {ADDR_BITS{1'b0}};
      count <= {(ADDR_BITS+1){1'b0}};
    end else begin
      rp <= rp_n;
      if (push_in) begin
        wp <= wp + 1'b1;
      end
      if (push_in && !full_out && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !push_in) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// *** src/serial_clock_divider.v ***
`timescale 1ns/10ps
// ****************************************
// half-period tick generator
// ****************************************
module serial_clock_divider (
  input wire clk_in,
  input wire reset_in,
  input wire run_in,
  input wire [7:0] divisor_in,
  output reg tick_out
);
  reg [7:0] count; // cycles into current half period
  // one tick every divisor+1 cycles while running
  always @(posedge clk_in) begin
    if (reset_in || !run_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (count == divisor_in) begin
      count <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule

// *** src/serial_flash_spi_master.v ***
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "serial_flash_defines.vh"
module serial_flash_spi_master #(
  parameter FIFO_ADDR_BITS = 4
) (
  input wire clk_in,
  input wire reset_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [7:0] reg_rdata_out,
  output reg irq_out,
  output reg flash_serial_clock_out,
  output reg flash_select_0_n_out,
  output reg flash_select_1_n_out,
  input wire [3:0] flash_io_in,
  output reg [3:0] flash_io_out,
  output reg [3:0] flash_io_oe_out,
  input wire [2:0] host_port_strap_in,
  input wire passthrough_pin_in,
  input wire host_sclk_in,
  input wire host_mosi_in,
  input wire host_cs_n_in,
  output reg host_miso_out,
  input wire fetch_req_in,
  input wire [31:0] fetch_addr_in,
  input wire [7:0] fetch_len_in,
  output reg [7:0] fetch_data_out,
  output reg fetch_valid_out,
  output reg fetch_busy_out
);
  // ****************************************
  // engine states
  // ****************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_XFER = 3'd1;
  localparam [2:0] S_CMD = 3'd2;
  localparam [2:0] S_ADDR = 3'd3;
  localparam [2:0] S_DUMMY = 3'd4;
  localparam [2:0] S_DATA = 3'd5;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [3:0] io_meta; // first stage, read only by io_sync
  reg [3:0] io_sync; // flash data lines
  reg [6:0] pin_meta; // first stage, read only by pin_sync
  reg [6:0] pin_sync; // strap, pass pin, host sclk, mosi, cs
  // two flops on every pin before use
  always @(posedge clk_in) begin
    if (reset_in) begin
      io_meta <= 4'h0;
      io_sync <= 4'h0;
      pin_meta <= 7'h01;
      pin_sync <= 7'h01;
    end else begin
      io_meta <= flash_io_in;
      io_sync <= io_meta;
      pin_meta <= {host_port_strap_in, passthrough_pin_in, host_sclk_in, host_mosi_in, host_cs_n_in};
      pin_sync <= pin_meta;
    end
  end
  // pass-through needs both strap and pin
  wire bypass = (pin_sync[6:4] == `STRAP_SERIAL4) && pin_sync[3];

  // ****************************************
  // registers and decode
  // ****************************************
  reg [7:0] ctrl; // master control
  reg [7:0] read_sel; // flash read mode selector
  reg [7:0] divisor; // serial clock divisor
  reg ovf_flag; // sticky transmit overflow
  reg emt_flag; // sticky transmit drained
  wire wr_data = reg_write_in && (reg_addr_in == `OFS_DATA);
  wire wr_ctrl = reg_write_in && (reg_addr_in == `OFS_CTRL);
  wire wr_status = reg_write_in && (reg_addr_in == `OFS_STATUS);
  wire rd_data = reg_read_in && (reg_addr_in == `OFS_DATA);
  wire active = ctrl[`CTRL_ACTIVE];
  // dropping select-active empties both fifos
  wire fifo_clear = wr_ctrl && !reg_wdata_in[`CTRL_ACTIVE];

  // ****************************************
  // engine registers
  // ****************************************
  reg [2:0] state; // engine state
  reg [1:0] lsh; // log2 of active lanes
  reg [5:0] cnt; // clocks left in segment
  reg phase; // next edge is trailing
  reg [31:0] sh; // outgoing shift register
  reg [7:0] rx; // incoming shift register
  reg [3:0] io_drv; // driven data lines
  reg [3:0] oe_drv; // data line enables
  reg sclk_lvl; // internal serial clock
  reg cs_act; // select asserted
  reg [31:0] f_addr; // pending fetch address
  reg [7:0] f_left; // fetch bytes left
  wire tick;
  wire [7:0] tx_head;
  wire [7:0] rx_head;
  wire tx_empty;
  wire tx_full;
  wire rx_empty;
  wire rx_full;

  // ****************************************
  // read mode table
  // ****************************************
  reg [7:0] m_op; // command opcode
  reg [1:0] m_cl; // command lanes, log2
  reg [1:0] m_al; // address lanes, log2
  reg [1:0] m_dl; // data lanes, log2
  reg [4:0] m_dummy; // dummy clocks
  wire a32 = read_sel[`SEL_A32];
  // selector decode, second opcode for 32-bit addressing except fastest and QPI fast
  always @* begin
    m_op = a32 ? `OP_NORMAL_32 : `OP_NORMAL_24;
    m_cl = 2'd0;
    m_al = 2'd0;
    m_dl = 2'd0;
    m_dummy = `DUMMY_NONE;
    case (read_sel[3:0])
      `RD_FAST: begin
        m_op = a32 ? `OP_FAST_32 : `OP_FAST_24;
        m_dummy = `DUMMY_8;
      end
      `RD_FASTEST: begin
        m_op = `OP_FASTEST;
        m_dummy = `DUMMY_16;
      end
      `RD_DUAL_OUT: begin
        m_op = a32 ? `OP_DUAL_OUT_32 : `OP_DUAL_OUT_24;
        m_dl = 2'd1;
        m_dummy = `DUMMY_8;
      end
      `RD_DUAL_IO: begin
        m_op = a32 ? `OP_DUAL_IO_32 : `OP_DUAL_IO_24;
        m_al = 2'd1;
        m_dl = 2'd1;
        m_dummy = `DUMMY_4;
      end
      `RD_QPI_FAST: begin
        m_op = `OP_FAST_24;
        m_cl = 2'd2;
        m_al = 2'd2;
        m_dl = 2'd2;
        m_dummy = `DUMMY_2;
      end
      `RD_QUAD_OUT: begin
        m_op = a32 ? `OP_QUAD_OUT_32 : `OP_QUAD_OUT_24;
        m_dl = 2'd2;
        m_dummy = `DUMMY_8;
      end
      default: begin
        m_dummy = `DUMMY_NONE;
      end
    endcase
  end

  // ****************************************
  // edge and lane helpers
  // ****************************************
  // flash reads always use mode 0; host bytes use the control mode
  wire pol = (state == S_XFER) ? ctrl[`CTRL_POL] : 1'b0;
  wire pha = (state == S_XFER) ? ctrl[`CTRL_PHA] : 1'b0;
  wire lead = tick && !phase;
  wire trail = tick && phase;
  wire sample_now = (lead && !pha) || (trail && pha);
  wire drive_now = (lead && pha) || (trail && !pha);
  wire seg_end = trail && (cnt == 6'd1);
  // wider lanes: highest bit on the highest line
  wire [7:0] rx_now = (lsh == 2'd2) ? {rx[3:0], io_sync[3:0]} :
                      (lsh == 2'd1) ? {rx[5:0], io_sync[1:0]} : {rx[6:0], io_sync[1]};
  wire [7:0] rx_cap = sample_now ? rx_now : rx;
  // start or continue host bytes while active and data waits
  wire start_gen = (state == S_IDLE) && active && !tx_empty && !bypass;
  wire next_gen = (state == S_XFER) && seg_end && active && !tx_empty && !fifo_clear;
  wire tx_pop = start_gen || next_gen;
  wire rx_push = (state == S_XFER) && seg_end;
  wire start_fetch = (state == S_IDLE) && fetch_busy_out && !active && !bypass;
  wire emt_set = (state == S_XFER) && seg_end && !next_gen;
  wire [5:0] addr_bits = a32 ? 6'd32 : 6'd24;

  // top lines for a given lane width
  function [3:0] lane_top;
    input [31:0] v;
    input [1:0] l;
    begin
      if (l == 2'd2) begin
        lane_top = v[31:28];
      end else if (l == 2'd1) begin
        lane_top = {2'b00, v[31:30]};
      end else begin
        lane_top = {3'b000, v[31]};
      end
    end
  endfunction

  // enables for a given lane width
  function [3:0] lane_mask;
    input [1:0] l;
    begin
      if (l == 2'd2) begin
        lane_mask = 4'hf;
      end else if (l == 2'd1) begin
        lane_mask = 4'h3;
      end else begin
        lane_mask = 4'h1;
      end
    end
  endfunction

  // ****************************************
  // fifos and divider
  // ****************************************
  serial_byte_fifo #(.WIDTH(8), .ADDR_BITS(FIFO_ADDR_BITS)) tx_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clear_in(fifo_clear),
    .push_in(wr_data),
    .push_data_in(reg_wdata_in),
    .pop_in(tx_pop),
    .head_out(tx_head),
    .empty_out(tx_empty),
    .full_out(tx_full)
  );
  serial_byte_fifo #(.WIDTH(8), .ADDR_BITS(FIFO_ADDR_BITS)) rx_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clear_in(fifo_clear),
    .push_in(rx_push),
    .push_data_in(rx_cap),
    .pop_in(rd_data),
    .head_out(rx_head),
    .empty_out(rx_empty),
    .full_out(rx_full)
  );
  serial_clock_divider clock_div (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(state != S_IDLE),
    .divisor_in(divisor),
    .tick_out(tick)
  );

  // ****************************************
  // register file
  // ****************************************
  // software writes; flags set wins over write-one-clear
  always @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= `CTRL_RESET;
      read_sel <= `READ_SEL_RESET;
      divisor <= `DIV_RESET;
      ovf_flag <= 1'b0;
      emt_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {1'b0, reg_wdata_in[6:0]};
      end
      if (reg_write_in && (reg_addr_in == `OFS_READ_SEL)) begin
        read_sel <= reg_wdata_in;
      end
      if (reg_write_in && (reg_addr_in == `OFS_DIVISOR)) begin
        divisor <= reg_wdata_in;
      end
      ovf_flag <= (wr_data && tx_full) || (ovf_flag && !(wr_status && reg_wdata_in[`ST_OVF]));
      emt_flag <= emt_set || (emt_flag && !(wr_status && reg_wdata_in[`ST_EMT]));
    end
  end

  // read answer one cycle after the strobe, zero otherwise
  always @(posedge clk_in) begin
    if (reset_in || !reg_read_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_addr_in == `OFS_READ_SEL) begin
      reg_rdata_out <= read_sel;
    end else if (reg_addr_in == `OFS_DATA) begin
      reg_rdata_out <= rx_head;
    end else if (reg_addr_in == `OFS_CTRL) begin
      reg_rdata_out <= ctrl;
    end else if (reg_addr_in == `OFS_STATUS) begin
      reg_rdata_out <= {tx_empty, tx_full, rx_empty, rx_full, ovf_flag, emt_flag, 1'b0,
                        state != S_IDLE};
    end else if (reg_addr_in == `OFS_DIVISOR) begin
      reg_rdata_out <= divisor;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // shift engine
  // ****************************************
  // one engine serves host bytes and flash fetches in turn
  always @(posedge clk_in) begin
    if (reset_in) begin
      state <= S_IDLE;
      lsh <= 2'd0;
      cnt <= 6'd0;
      phase <= 1'b0;
      sh <= 32'h0;
      rx <= 8'h00;
      io_drv <= 4'h0;
      oe_drv <= 4'h0;
      sclk_lvl <= 1'b0;
      cs_act <= 1'b0;
      f_addr <= 32'h0;
      f_left <= 8'h00;
      fetch_busy_out <= 1'b0;
      fetch_valid_out <= 1'b0;
      fetch_data_out <= 8'h00;
    end else begin
      fetch_valid_out <= 1'b0;
      // a new fetch is taken only when none is pending
      if (fetch_req_in && !fetch_busy_out) begin
        fetch_busy_out <= 1'b1;
        f_addr <= fetch_addr_in;
        f_left <= fetch_len_in;
      end
      if (tick) begin
        phase <= ~phase;
        sclk_lvl <= phase ? pol : ~pol;
      end
      if (sample_now) begin
        rx <= rx_now;
      end
      if (drive_now) begin
        io_drv <= lane_top(sh, lsh);
        sh <= sh << (3'd1 << lsh); // one bit per active lane
      end
      if (trail) begin
        cnt <= cnt - 6'd1;
      end
      case (state)
        S_IDLE: begin
          phase <= 1'b0;
          sclk_lvl <= ctrl[`CTRL_POL];
          cs_act <= active;
          if (start_gen) begin
            // mode with phase 0 puts the first bit out before any edge
            state <= S_XFER;
            lsh <= 2'd0;
            cnt <= 6'd8;
            oe_drv <= 4'h1;
            io_drv <= {3'b000, tx_head[7]};
            sh <= ctrl[`CTRL_PHA] ? {tx_head, 24'h0} : {tx_head[6:0], 25'h0};
          end else if (start_fetch) begin
            state <= S_CMD;
            cs_act <= 1'b1;
            lsh <= m_cl;
            cnt <= 6'd8 >> m_cl;
            oe_drv <= lane_mask(m_cl);
            io_drv <= lane_top({m_op, 24'h0}, m_cl);
            sh <= {m_op, 24'h0} << (3'd1 << m_cl);
          end
        end
        S_XFER: begin
          if (fifo_clear) begin
            state <= S_IDLE;
          end else if (next_gen) begin
            cnt <= 6'd8;
            io_drv <= ctrl[`CTRL_PHA] ? io_drv : {3'b000, tx_head[7]};
            sh <= ctrl[`CTRL_PHA] ? {tx_head, 24'h0} : {tx_head[6:0], 25'h0};
          end else if (seg_end) begin
            state <= S_IDLE;
          end
        end
        S_CMD: begin
          if (seg_end) begin
            // address follows, top byte unused for 24-bit
            state <= S_ADDR;
            lsh <= m_al;
            cnt <= addr_bits >> m_al;
            oe_drv <= lane_mask(m_al);
            io_drv <= lane_top(a32 ? f_addr : {f_addr[23:0], 8'h00}, m_al);
            sh <= (a32 ? f_addr : {f_addr[23:0], 8'h00}) << (3'd1 << m_al);
          end
        end
        S_ADDR: begin
          if (seg_end) begin
            oe_drv <= 4'h0;
            lsh <= m_dl;
            if (m_dummy != `DUMMY_NONE) begin
              state <= S_DUMMY;
              cnt <= {1'b0, m_dummy};
            end else begin
              state <= S_DATA;
              cnt <= 6'd8 >> m_dl;
            end
          end
        end
        S_DUMMY: begin
          if (seg_end) begin
            state <= S_DATA;
            cnt <= 6'd8 >> m_dl;
          end
        end
        S_DATA: begin
          if (seg_end) begin
            fetch_valid_out <= 1'b1;
            fetch_data_out <= rx_cap;
            f_left <= f_left - 8'h01;
            cnt <= 6'd8 >> m_dl;
            if (f_left == 8'h01) begin
              state <= S_IDLE;
              cs_act <= 1'b0;
              fetch_busy_out <= 1'b0;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  // pass-through costs three cycles of pin delay; fine for slow host clocks
  always @(posedge clk_in) begin
    if (reset_in) begin
      flash_serial_clock_out <= 1'b0;
      flash_select_0_n_out <= 1'b1;
      flash_select_1_n_out <= 1'b1;
      flash_io_out <= 4'h0;
      flash_io_oe_out <= 4'h0;
      host_miso_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      irq_out <= !ctrl[`CTRL_MASK] && ((ovf_flag && ctrl[`CTRL_OVF_EN]) ||
                 (emt_flag && ctrl[`CTRL_EMT_EN]));
      host_miso_out <= io_sync[1];
      if (bypass) begin
        flash_serial_clock_out <= pin_sync[2];
        flash_io_out <= {3'b000, pin_sync[1]};
        flash_io_oe_out <= 4'h1;
        flash_select_0_n_out <= ctrl[`CTRL_CS_SEL] | pin_sync[0];
        flash_select_1_n_out <= !ctrl[`CTRL_CS_SEL] | pin_sync[0];
      end else begin
        flash_serial_clock_out <= sclk_lvl;
        flash_io_out <= io_drv;
        flash_io_oe_out <= oe_drv;
        flash_select_0_n_out <= !(cs_act && !ctrl[`CTRL_CS_SEL]);
        flash_select_1_n_out <= !(cs_act && ctrl[`CTRL_CS_SEL]);
      end
    end
  end
endmodule

// *** test/serial_flash_sva.sv ***
`timescale 1ns/10ps
// ****
// port checker
// ****
module serial_flash_sva #(
  parameter FIFO_ADDR_BITS = 4
) (
  input wire clk_in,
  input wire reset_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  input wire [7:0] reg_rdata_out,
  input wire irq_out,
  input wire flash_serial_clock_out,
  input wire flash_select_0_n_out,
  input wire flash_select_1_n_out,
  input wire fetch_req_in,
  input wire fetch_valid_out,
  input wire fetch_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire ctrl_wr = reg_write_in && reg_addr_in == 8'hb9; // control write
  wire idle = flash_select_0_n_out && flash_select_1_n_out; // nothing selected
  a_rdata_quiet: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (reg_read_in && (reg_addr_in < 8'hb7 || reg_addr_in > 8'hbb) |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_select_zero: assert property (ctrl_wr && reg_wdata_in[5:4] == 2'b01 |->
    ##[1:4] !flash_select_0_n_out && flash_select_1_n_out) else $error("select 0 not driven");
  a_select_one: assert property (ctrl_wr && reg_wdata_in[5:4] == 2'b11 |->
    ##[1:4] flash_select_0_n_out && !flash_select_1_n_out) else $error("select 1 not driven");
  a_single_select: assert property (flash_select_0_n_out || flash_select_1_n_out)
    else $error("both selects low");
  a_mask_irq: assert property (ctrl_wr && reg_wdata_in[6] |-> ##[2:3] !irq_out)
    else $error("masked interrupt still high");
  // clock must not move while nobody is selected
  a_sclk_still: assert property (idle && $past(idle) |-> $stable(flash_serial_clock_out))
    else $error("serial clock moved while idle");
  a_valid_pulse: assert property (fetch_valid_out |=> !fetch_valid_out)
    else $error("fetch valid longer than one cycle");
  a_busy_start: assert property (fetch_req_in && !fetch_busy_out |=> fetch_busy_out)
    else $error("fetch not taken");
endmodule

// *** test/flash_partner.sv ***
`timescale 1ns/10ps
// ****
// flash side, wired as loopback
// ****
module flash_partner (
  input wire clk_in,
  input wire sel_n_in,
  input wire [3:0] io_out_in,
  input wire [3:0] oe_in,
  output wire [3:0] io_in_out
);
  reg churn = 1'b0; // released lines toggle so stale values never pass
  always @(posedge clk_in) begin
    churn <= ~churn;
  end
  // selected: io1 echoes io0, erased flash reads ones when io0 floats
  wire echo = sel_n_in ? churn : (oe_in[0] ? io_out_in[0] : 1'b1);
  assign io_in_out[0] = oe_in[0] ? io_out_in[0] : churn;
  assign io_in_out[1] = oe_in[1] ? io_out_in[1] : echo;
  assign io_in_out[2] = oe_in[2] ? io_out_in[2] : churn;
  assign io_in_out[3] = oe_in[3] ? io_out_in[3] : ~churn;
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
// ****
// bench
// ****
module tb_top;
  reg clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg [7:0] addr = 8'h00, wdata = 8'h00, flen = 8'h02;
  reg wr = 1'b0, rd = 1'b0, freq = 1'b0, rd_seen = 1'b0;
  reg [31:0] faddr = 32'h0;
  reg [2:0] strap = 3'b000;
  reg pass = 1'b0, hsclk = 1'b0, hmosi = 1'b0, hcs_n = 1'b1, sclk_q = 1'b0;
  reg [39:0] cap = 40'h0; // command and address bits seen by the flash
  wire [7:0] rdata, fdata;
  wire irq, sclk, s0_n, s1_n, fvalid, fbusy, miso;
  wire [3:0] io_in, io_out, io_oe;
  int fails = 0, total_checks = 0, seed, nvalid = 0, i, m, k;
  logic [15:0] notes[$]; // {care mask, expected}
  logic [7:0] d[17];
  always #25 clk_in = ~clk_in;
  serial_flash_spi_master serial_flash_spi_master_inst (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq), .flash_serial_clock_out(sclk),
    .flash_select_0_n_out(s0_n), .flash_select_1_n_out(s1_n), .flash_io_in(io_in),
    .flash_io_out(io_out), .flash_io_oe_out(io_oe), .host_port_strap_in(strap),
    .passthrough_pin_in(pass), .host_sclk_in(hsclk), .host_mosi_in(hmosi), .host_cs_n_in(hcs_n),
    .host_miso_out(miso), .fetch_req_in(freq), .fetch_addr_in(faddr), .fetch_len_in(flen),
    .fetch_data_out(fdata), .fetch_valid_out(fvalid), .fetch_busy_out(fbusy));
  flash_partner flash_partner_inst (.clk_in(clk_in), .sel_n_in(s0_n & s1_n),
    .io_out_in(io_out), .oe_in(io_oe), .io_in_out(io_in));
  // one bus cycle, strobes set once per edge
  task bus(input w, input r, input [7:0] a, input [7:0] v, input [15:0] n);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
    if (r) notes.push_back(n);
    @(posedge clk_in);
  endtask
  task wr8(input [7:0] a, input [7:0] v);
    bus(1'b1, 1'b0, a, v, 16'h0000);
  endtask
  task rd8(input [7:0] a, input [7:0] msk, input [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00, {msk, e & msk});
  endtask
  // completion shows as the empty interrupt
  task wait_irq;
    bus(1'b0, 1'b0, 8'h00, 8'h00, 16'h0000);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (irq !== 1'b1 && k < 3000);
    `CHK("irq", 1'b1, irq)
    @(posedge clk_in);
  endtask
  // flash samples command and address on the rising serial clock
  always @(posedge clk_in) begin
    sclk_q <= sclk;
    if (freq) cap <= 40'h0;
    else if (sclk && !sclk_q && !(s0_n & s1_n) && io_oe[0]) cap <= {cap[38:0], io_out[0]};
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) rd_seen <= rd;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      `CHK("read data", notes[0][7:0], rdata & notes[0][15:8])
      void'(notes.pop_front());
    end
    if (fvalid === 1'b1) begin
      nvalid++;
      `CHK("fetch data", 8'hff, fdata)
    end
  end
  initial begin
    #1000000;
    fails++;
    close_out;
  end
  initial begin
    seed = $urandom(68335);
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    rd8(8'hb7, 8'hff, 8'h00);
    rd8(8'hb9, 8'hff, 8'h00);
    rd8(8'hbb, 8'hff, 8'h1f);
    rd8(8'hba, 8'hff, 8'ha0);
    rd8(8'hb0, 8'hff, 8'h00);
    wr8(8'hb7, 8'h25);
    rd8(8'hb7, 8'h2f, 8'h25);
    wr8(8'hbb, 8'h03); // 400 ns serial period
    // loopback in all four clock modes, both selects
    for (m = 0; m < 4; m++) begin
      wr8(8'hb9, {2'b00, m[1], 3'b101, m[1:0]});
      wr8(8'hba, 8'h04);
      for (i = 0; i < 4; i++) begin
        d[i] = (m + i == 0) ? 8'h38 : 8'($urandom);
        wr8(8'hb8, d[i]);
      end
      wait_irq;
      wr8(8'hb9, {2'b01, m[1], 3'b101, m[1:0]});
      wr8(8'hba, 8'h04);
      for (i = 0; i < 4; i++) rd8(8'hb8, 8'hff, d[i]);
      rd8(8'hba, 8'hff, 8'ha0);
      wr8(8'hb9, 8'h00);
    end
    // overflow: oldest entry replaced, read side unmoved
    wr8(8'hb9, 8'h08);
    wr8(8'hba, 8'h0c);
    rd8(8'hba, 8'h20, 8'h20);
    for (i = 0; i < 17; i++) begin
      d[i] = 8'($urandom);
      wr8(8'hb8, d[i]);
    end
    rd8(8'hba, 8'hc8, 8'h48);
    bus(1'b0, 1'b0, 8'h00, 8'h00, 16'h0000);
    @(negedge clk_in);
    `CHK("irq", 1'b1, irq)
    @(posedge clk_in);
    wr8(8'hba, 8'h08);
    wr8(8'hb9, 8'h14);
    wr8(8'hba, 8'h04);
    wait_irq;
    for (i = 0; i < 15; i++) rd8(8'hb8, 8'hff, d[i == 0 ? 16 : i]);
    wr8(8'hb9, 8'h08);
    wr8(8'hb8, 8'h5a);
    wr8(8'hb9, 8'h00);
    rd8(8'hba, 8'hf0, 8'ha0);
    // flash fetch, normal read 24-bit, then fast read 32-bit
    for (m = 0; m < 2; m++) begin
      wr8(8'hb7, m ? 8'h24 : 8'h00);
      freq <= 1'b1;
      faddr <= $urandom;
      wr <= 1'b0;
      @(posedge clk_in);
      freq <= 1'b0;
      for (k = 0; k < 3000 && !(nvalid == 2 * m + 2 && fbusy === 1'b0); k++) @(posedge clk_in);
      `CHK("fetched bytes", 2 * m + 2, nvalid)
      `CHK("command and address", m ? {8'h0c, faddr} : {16'h0003, faddr[23:0]}, cap)
    end
    // pass-through: host pins reach the flash directly
    strap <= 3'b101;
    pass <= 1'b1;
    hsclk <= 1'b1;
    hmosi <= 1'b1;
    hcs_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK("bypass clock", 1'b1, sclk)
    `CHK("bypass data", 1'b1, miso)
    close_out;
  end
endmodule
bind serial_flash_spi_master serial_flash_sva #(.FIFO_ADDR_BITS(FIFO_ADDR_BITS)) checker_inst (
  .clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
  .irq_out, .flash_serial_clock_out, .flash_select_0_n_out, .flash_select_1_n_out,
  .fetch_req_in, .fetch_valid_out, .fetch_busy_out);
